// >>> bench/rls_prog_mem.sv
// Program memory model supplying encoded return and loop setup words
`timescale 1ns/1ps
module rls_prog_mem (
	input wire logic [4:0] addr_i,
	output logic [31:0] word_o
);
	always_comb begin
		case (addr_i)
			5'h00: word_o = {3'h1, 5'h1F, 5'h01, 19'h0};
			5'h01, 5'h02, 5'h05, 5'h06: word_o = {3'h1, 5'h01, 5'h01, 19'h0};
			// Else forms always carry a real condition
			5'h03, 5'h04, 5'h07: word_o = {3'h1, 5'h01, 5'h03, 19'h0};
			// Reentry kept to subroutine returns, one plain and one delayed
			5'h08: word_o = {3'h1, 5'h1F, 5'h04, 19'h0};
			5'h09: word_o = {3'h1, 5'h1F, 5'h08, 19'h0};
			5'h0A: word_o = {3'h1, 5'h1F, 5'h0C, 19'h0};
			5'h0B: word_o = {3'h1, 5'h1F, 5'h10, 19'h0};
			5'h0C: word_o = {3'h1, 5'h1F, 5'h18, 19'h0};
			5'h0D: word_o = {3'h1, 5'h01, 5'h00, 19'h0};
			5'h0E: word_o = {3'h1, 5'h1F, 5'h10, 19'h3};
			5'h0F: word_o = {3'h2, 5'h00, 2'h2, 6'h00, 16'h0005};
			5'h10: word_o = {3'h2, 5'h00, 2'h1, 6'h00, 16'hFFFE};
			default: word_o = 32'h0;
		endcase
	end
endmodule : rls_prog_mem

// >>> bench/rls_sequencer_bench.sv
// Self-checking bench of the return and loop setup sequencer
`timescale 1ns/1ps
`include "rls_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module rls_sequencer_bench;
	typedef struct packed {
		logic p, cp, cs, ld, ep, es;
	} rls_row_s;
	logic clk, rst_n, psel, penable, pwrite, cp, cs, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, word;
	logic pready, pslverr, fload, cmp_p, cmp_s, cmp_c, fstage;
	logic [23:0] faddr;
	logic [4:0] ma;
	int n_fail, total_checks;
	// Columns: paired, cond primary, cond secondary, load, compute primary, compute secondary
	rls_row_s rows [14] = '{6'h06, 6'h16, 6'h00, 6'h02, 6'h14, 6'h32, 6'h3F, 6'h31,
		6'h04, 6'h04, 6'h04, 6'h04, 6'h04, 6'h00};
	rls_sequencer #(.STACK_DEPTH(8)) uut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.COND_PRIMARY_I(cp), .COND_SECONDARY_I(cs), .FETCH_ADDR_O(faddr),
		.FETCH_LOAD_O(fload), .COMPUTE_PRIMARY_O(cmp_p), .COMPUTE_SECONDARY_O(cmp_s),
		.SECONDARY_COMPLEMENT_O(cmp_c), .FETCH_STAGE_LOOP_O(fstage));
	rls_prog_mem mem (.addr_i(ma), .word_o(word));
	always #5 clk = ~clk;
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) n_fail++;
	endtask : apb
	task automatic issue(input logic p);
		apb(1'b1, `RLS_A_INSTR, word);
		apb(1'b1, `RLS_A_CTRL, {30'h0, 1'b1, p});
	endtask : issue
	task report_and_stop;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		{clk, rst_n, psel, penable, pwrite, cp, cs} = 7'h00;
		{paddr, pwdata, ma, n_fail, total_checks} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK({fload, cmp_p, cmp_s, cmp_c, fstage}, 5'h00)
		apb(1'b0, `RLS_A_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		for (int i = 0; i < 14; i++) begin
			ma = 5'(i);
			apb(1'b1, `RLS_A_PC, 32'h100 + i);
			apb(1'b1, `RLS_A_PUSHSEL, 32'h1);
			cp <= rows[i].cp;
			cs <= rows[i].cs;
			issue(rows[i].p);
			// Compute and non-delayed redirect pulses stand for the single cycle after the issue slot
			@(posedge clk);
			#1;
			`CHK({cmp_p, cmp_s, cmp_c}, {rows[i].ep, rows[i].es, rows[i].p & word[`RLS_CMP_BIT]})
			if (word[22]) begin
				`CHK(fload, 1'b0)
				repeat (2) @(posedge clk);
				#1;
			end
			`CHK(fload, rows[i].ld)
			if (rows[i].ld) begin
				`CHK(faddr, 24'(32'h100 + i))
			end else begin
				apb(1'b0, `RLS_A_PCSTK, 32'h0);
				`CHK(rd[23:0], 24'(32'h100 + i))
			end
		end
		// Status pushed for interrupt 3 only, then return from it
		ma = 5'h0E;
		apb(1'b1, `RLS_A_LATCH, 32'hFF);
		apb(1'b1, `RLS_A_MASKP, 32'hFF);
		apb(1'b1, `RLS_A_CMPEN, 32'h8);
		apb(1'b1, `RLS_A_STATUS, 32'h0001_0002);
		apb(1'b1, `RLS_A_PUSHSEL, 32'h2);
		apb(1'b1, `RLS_A_STATUS, 32'h0);
		apb(1'b1, `RLS_A_PC, 32'h300);
		apb(1'b1, `RLS_A_PUSHSEL, 32'h1);
		issue(1'b0);
		repeat (3) @(posedge clk);
		apb(1'b0, `RLS_A_STATUS, 32'h0);
		`CHK(rd, 32'h0001_0002)
		apb(1'b0, `RLS_A_LATCH, 32'h0);
		`CHK(rd, 32'hF7)
		apb(1'b0, `RLS_A_MASKP, 32'h0);
		`CHK(rd, 32'hF7)
		// Absolute end, fetch-stage loop
		ma = 5'h0F;
		apb(1'b1, `RLS_A_PC, 32'h200);
		issue(1'b0);
		repeat (3) @(posedge clk);
		apb(1'b0, `RLS_A_COUNT, 32'h0);
		`CHK(rd, 32'h5)
		apb(1'b0, `RLS_A_CSTK, 32'h0);
		`CHK(rd, 32'h5)
		apb(1'b0, `RLS_A_LSTK, 32'h0);
		`CHK(rd, {3'h0, 24'h000005, 5'h0F})
		`CHK(fstage, 1'b1)
		// Relative end with negative offset, execute-stage loop
		ma = 5'h10;
		apb(1'b1, `RLS_A_PC, 32'h200);
		issue(1'b0);
		repeat (3) @(posedge clk);
		apb(1'b0, `RLS_A_COUNT, 32'h0);
		`CHK(rd, 32'h0000_FFFE)
		apb(1'b0, `RLS_A_LSTK, 32'h0);
		`CHK(rd, {3'h0, 24'h0001FE, 5'h0F})
		`CHK(fstage, 1'b0)
		// Decrement slot at loop end minus two, skipped once after a reentry return
		for (int k = 0; k < 4; k++) begin
			ma = (k == 1) ? 5'h08 : 5'h0D;
			apb(1'b1, `RLS_A_PC, (k == 1) ? 32'h1F0 : 32'h1FC);
			issue(1'b0);
			repeat (3) @(posedge clk);
			apb(1'b0, `RLS_A_COUNT, 32'h0);
			`CHK(rd, (k == 3) ? 32'h0000_FFFC : 32'h0000_FFFD)
		end
		// Mid-run reset clears the loop state
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK({fload, cmp_p, cmp_s, cmp_c, fstage}, 5'h00)
		apb(1'b0, `RLS_A_COUNT, 32'h0);
		`CHK(rd, 32'h0)
		// Unmapped address is refused
		apb(1'b0, 8'hFC, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		report_and_stop;
	end
endmodule : rls_sequencer_bench

// >>> logic/rls_map.svh
// Field positions, encodings and register offsets of the return and loop setup sequencer
`ifndef RLS_MAP_SVH
`define RLS_MAP_SVH
`define RLS_OP_MSB 31
`define RLS_OP_LSB 29
`define RLS_OP_RET 3'h1
`define RLS_OP_LOOP 3'h2
`define RLS_COND_MSB 28
`define RLS_COND_LSB 24
`define RLS_COND_ALWAYS 5'h1F
`define RLS_RET_X_BIT 23
`define RLS_RET_J_BIT 22
`define RLS_RET_REENTRY_BIT 21
`define RLS_ELSE_BIT 20
`define RLS_CMP_BIT 19
`define RLS_IVEC_MSB 4
`define RLS_IVEC_LSB 0
`define RLS_MODE_BIT 23
`define RLS_REL_BIT 22
`define RLS_CNT_MSB 15
`define RLS_CNT_LSB 0
`define RLS_LOOPEND_OFS 24'h000002
`define RLS_LCE_TERM 5'h0F
`define RLS_A_CTRL 8'h00
`define RLS_A_INSTR 8'h04
`define RLS_A_PC 8'h08
`define RLS_A_ENDADDR 8'h0C
`define RLS_A_STATUS 8'h10
`define RLS_A_LATCH 8'h14
`define RLS_A_MASKP 8'h18
`define RLS_A_COUNT 8'h1C
`define RLS_A_PCSTK 8'h20
`define RLS_A_STSTK 8'h24
`define RLS_A_LSTK 8'h28
`define RLS_A_CSTK 8'h2C
`define RLS_A_CMPEN 8'h30
`define RLS_A_PUSHSEL 8'h34
`define RLS_STS_ARITH_LSB 0
`define RLS_STS_MODE_LSB 16
`endif

// >>> logic/rls_pkg.sv
// Types shared by the return and loop setup sequencer
package rls_pkg;
	typedef enum logic [1:0] {
		RLS_IDLE,
		RLS_DELAY1,
		RLS_DELAY2
	} rls_state_e;
	typedef struct packed {
		logic interrupt_return;
		logic delayed_option;
		logic loop_reentry_option;
		logic else_form;
		logic has_compute;
	} rls_ret_s;
	typedef struct packed {
		logic [23:0] end_addr;
		logic [4:0] term;
		logic fetch_stage;
	} rls_loop_s;
endpackage : rls_pkg

// >>> logic/rls_sequencer.sv
// Return and counter-loop setup sequencer with APB register access
//
// What this block does
// - Taken return fetches from PC stack top
// - Interrupt return pops status stack when pushed
// - Interrupt return clears latch and mask pointer bit
// - Return taken if condition true or field all-ones
// - Kind bits: interrupt, delayed, loop reentry
// - Delayed option gives delayed branch return
// - Loop reentry return suppresses second count decrement
// - Decrement count two places before loop end
// - Paired mode needs condition true in both elements
// - Plain compute runs per element when true
// - Else compute runs per element when false
// - Secondary element uses complementary registers
// - Loop setup loads unsigned 16-bit count
// - Push start to PC stack, end plus term
// - End address absolute or PC-relative offset
// - Count pushed, becomes current, loop until zero
// - Bit 23 selects execute or fetch stage loop
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "rls_map.svh"
module rls_sequencer #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic COND_PRIMARY_I,
	input wire logic COND_SECONDARY_I,
	output logic [23:0] FETCH_ADDR_O,
	output logic FETCH_LOAD_O,
	output logic COMPUTE_PRIMARY_O,
	output logic COMPUTE_SECONDARY_O,
	output logic SECONDARY_COMPLEMENT_O,
	output logic FETCH_STAGE_LOOP_O
);
	// Control register: bit0 paired mode, bit1 issue strobe
	logic paired_element_mode_q;
	logic [31:0] instr_q;
	logic [23:0] pc_q;
	logic [15:0] arith_status_reg_q;
	logic [15:0] mode_control_reg_one_q;
	logic [31:0] interrupt_latch_reg_q;
	logic [31:0] interrupt_mask_pointer_q;
	logic [31:0] status_pushed_q;
	logic [15:0] current_loop_count_q;
	logic [23:0] end_addr_q;
	logic decr_skip_q;
	logic issue_q;
	rls_pkg::rls_state_e state_q;
	rls_pkg::rls_state_e state_d;
	logic [23:0] target_q;
	// APB decode
	wire apb_acc = PSEL_I && PENABLE_I;
	wire apb_wr = apb_acc && PWRITE_I;
	wire apb_rd = apb_acc && !PWRITE_I;
	wire wr_ctrl = apb_wr && (PADDR_I == `RLS_A_CTRL);
	wire wr_instr = apb_wr && (PADDR_I == `RLS_A_INSTR);
	wire wr_pc = apb_wr && (PADDR_I == `RLS_A_PC);
	wire wr_status = apb_wr && (PADDR_I == `RLS_A_STATUS);
	wire wr_latch = apb_wr && (PADDR_I == `RLS_A_LATCH);
	wire wr_maskp = apb_wr && (PADDR_I == `RLS_A_MASKP);
	wire wr_push = apb_wr && (PADDR_I == `RLS_A_PUSHSEL);
	wire wr_cmpen = apb_wr && (PADDR_I == `RLS_A_CMPEN);
	// Instruction fields
	wire [2:0] opcode = instr_q[`RLS_OP_MSB:`RLS_OP_LSB];
	wire [4:0] cond_field = instr_q[`RLS_COND_MSB:`RLS_COND_LSB];
	wire [4:0] ivec = instr_q[`RLS_IVEC_MSB:`RLS_IVEC_LSB];
	rls_pkg::rls_ret_s ret;
	assign ret.interrupt_return = instr_q[`RLS_RET_X_BIT];
	assign ret.delayed_option = instr_q[`RLS_RET_J_BIT];
	// Reentry only meaningful for subroutine return
	assign ret.loop_reentry_option = instr_q[`RLS_RET_REENTRY_BIT] && !instr_q[`RLS_RET_X_BIT];
	assign ret.else_form = instr_q[`RLS_ELSE_BIT];
	assign ret.has_compute = instr_q[`RLS_CMP_BIT];
	wire is_ret = issue_q && (opcode == `RLS_OP_RET);
	wire is_loop = issue_q && (opcode == `RLS_OP_LOOP);
	wire uncond = (cond_field == `RLS_COND_ALWAYS);
	wire cond_both = COND_PRIMARY_I && (!paired_element_mode_q || COND_SECONDARY_I);
	wire ret_true = uncond || cond_both;
	wire ret_take = is_ret && ret_true;
	wire ret_irq = ret_take && ret.interrupt_return;
	wire p_true = uncond || COND_PRIMARY_I;
	wire s_true = uncond || COND_SECONDARY_I;
	// Loop end formation
	rls_pkg::rls_loop_s lp;
	wire [15:0] end_ofs = instr_q[`RLS_CNT_MSB:`RLS_CNT_LSB];
	assign lp.end_addr = instr_q[`RLS_REL_BIT] ?
		pc_q + {{8{end_ofs[15]}}, end_ofs} : {8'h00, end_ofs};
	assign lp.term = `RLS_LCE_TERM;
	assign lp.fetch_stage = instr_q[`RLS_MODE_BIT];
	// Stack buses
	logic [23:0] pc_top;
	logic [31:0] st_top;
	logic [28:0] ls_top;
	logic [15:0] cs_top;
	logic [$clog2(STACK_DEPTH):0] pc_lvl, st_lvl, ls_lvl, cs_lvl;
	wire pc_pop = ret_take;
	wire pc_push = is_loop || (wr_push && PWDATA_I[0]);
	wire [23:0] pc_wdata = is_loop ? (pc_q + 24'h000001) : pc_q;
	wire st_push = wr_push && PWDATA_I[1];
	wire irq_pushed = status_pushed_q[ivec];
	wire st_pop = ret_irq && irq_pushed;
	wire ls_push = is_loop;
	wire cs_push = is_loop;
	// Counted once per executed instruction, not per idle clock parked at that address
	wire at_decr = issue_q && (current_loop_count_q != 16'h0000) &&
		(end_addr_q != 24'h000000) && (pc_q == end_addr_q - `RLS_LOOPEND_OFS);
	wire do_decr = at_decr && !decr_skip_q;
	wire cs_pop = do_decr && (current_loop_count_q == 16'h0001);
	rls_stack #(.WIDTH(24), .DEPTH(STACK_DEPTH)) u_pc_stack (
		.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .push_i(pc_push), .pop_i(pc_pop),
		.wdata_i(pc_wdata), .top_o(pc_top), .level_o(pc_lvl));
	rls_stack #(.WIDTH(32), .DEPTH(STACK_DEPTH)) u_status_stack (
		.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .push_i(st_push), .pop_i(st_pop),
		.wdata_i({mode_control_reg_one_q, arith_status_reg_q}), .top_o(st_top),
		.level_o(st_lvl));
	rls_stack #(.WIDTH(29), .DEPTH(STACK_DEPTH)) u_loop_stack (
		.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .push_i(ls_push), .pop_i(cs_pop),
		.wdata_i({lp.end_addr, lp.term}), .top_o(ls_top), .level_o(ls_lvl));
	rls_stack #(.WIDTH(16), .DEPTH(STACK_DEPTH)) u_count_stack (
		.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .push_i(cs_push), .pop_i(cs_pop),
		.wdata_i(instr_q[`RLS_CNT_MSB:`RLS_CNT_LSB]), .top_o(cs_top), .level_o(cs_lvl));
	// Sequencer state: delayed return waits two slots before redirect
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			rls_pkg::RLS_IDLE: begin
				if (ret_take && ret.delayed_option) begin
					state_d = rls_pkg::RLS_DELAY1;
				end
			end
			rls_pkg::RLS_DELAY1: state_d = rls_pkg::RLS_DELAY2;
			rls_pkg::RLS_DELAY2: state_d = rls_pkg::RLS_IDLE;
		endcase
	end
	wire redirect_now = (ret_take && !ret.delayed_option) || (state_q == rls_pkg::RLS_DELAY2);
	wire [23:0] redirect_addr = (state_q == rls_pkg::RLS_DELAY2) ? target_q : pc_top;
	wire [31:0] ivec_bit = 32'h00000001 << ivec;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			state_q <= rls_pkg::RLS_IDLE;
			target_q <= 24'h000000;
			issue_q <= 1'b0;
			instr_q <= 32'h00000000;
			paired_element_mode_q <= 1'b0;
			status_pushed_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			if (ret_take) begin
				target_q <= pc_top;
			end
			// Issue strobe is one cycle; a new write while busy is ignored
			issue_q <= wr_ctrl && PWDATA_I[1] && (state_q == rls_pkg::RLS_IDLE);
			if (wr_instr) begin
				instr_q <= PWDATA_I;
			end
			if (wr_ctrl) begin
				paired_element_mode_q <= PWDATA_I[0];
			end
			if (wr_cmpen) begin
				status_pushed_q <= PWDATA_I;
			end
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			pc_q <= 24'h000000;
		end else if (redirect_now) begin
			pc_q <= redirect_addr;
		end else if (wr_pc) begin
			pc_q <= PWDATA_I[23:0];
		end else if (issue_q || state_q != rls_pkg::RLS_IDLE) begin
			// Not taken return: next sequential instruction
			pc_q <= pc_q + 24'h000001;
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			arith_status_reg_q <= 16'h0000;
			mode_control_reg_one_q <= 16'h0000;
		end else if (st_pop) begin
			arith_status_reg_q <= st_top[`RLS_STS_ARITH_LSB +: 16];
			mode_control_reg_one_q <= st_top[`RLS_STS_MODE_LSB +: 16];
		end else if (wr_status) begin
			arith_status_reg_q <= PWDATA_I[15:0];
			mode_control_reg_one_q <= PWDATA_I[31:16];
		end
	end
	// Hardware clear wins over a software write in the same cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			interrupt_latch_reg_q <= 32'h00000000;
			interrupt_mask_pointer_q <= 32'h00000000;
		end else begin
			if (ret_irq) begin
				interrupt_latch_reg_q <= (wr_latch ? PWDATA_I : interrupt_latch_reg_q) & ~ivec_bit;
			end else if (wr_latch) begin
				interrupt_latch_reg_q <= PWDATA_I;
			end
			if (ret_irq) begin
				interrupt_mask_pointer_q <= (wr_maskp ? PWDATA_I : interrupt_mask_pointer_q) & ~ivec_bit;
			end else if (wr_maskp) begin
				interrupt_mask_pointer_q <= PWDATA_I;
			end
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			current_loop_count_q <= 16'h0000;
			end_addr_q <= 24'h000000;
			decr_skip_q <= 1'b0;
			FETCH_STAGE_LOOP_O <= 1'b0;
		end else if (is_loop) begin
			current_loop_count_q <= instr_q[`RLS_CNT_MSB:`RLS_CNT_LSB];
			end_addr_q <= lp.end_addr;
			decr_skip_q <= 1'b0;
			FETCH_STAGE_LOOP_O <= lp.fetch_stage;
		end else begin
			if (do_decr) begin
				current_loop_count_q <= current_loop_count_q - 16'h0001;
			end
			// Reentry return re-runs the decrement slot without counting it
			if (ret_take && ret.loop_reentry_option) begin
				decr_skip_q <= 1'b1;
			end else if (at_decr) begin
				decr_skip_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			FETCH_ADDR_O <= 24'h000000;
			FETCH_LOAD_O <= 1'b0;
			COMPUTE_PRIMARY_O <= 1'b0;
			COMPUTE_SECONDARY_O <= 1'b0;
			SECONDARY_COMPLEMENT_O <= 1'b0;
		end else begin
			FETCH_LOAD_O <= redirect_now;
			FETCH_ADDR_O <= redirect_now ? redirect_addr : FETCH_ADDR_O;
			COMPUTE_PRIMARY_O <= is_ret && ret.has_compute &&
				(ret.else_form ? !p_true : p_true);
			COMPUTE_SECONDARY_O <= is_ret && ret.has_compute && paired_element_mode_q &&
				(ret.else_form ? !s_true : s_true);
			SECONDARY_COMPLEMENT_O <= is_ret && ret.has_compute && paired_element_mode_q;
		end
	end
	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (PADDR_I)
			`RLS_A_CTRL: rd_mux = {29'h0, state_q != rls_pkg::RLS_IDLE, 1'b0, paired_element_mode_q};
			`RLS_A_INSTR: rd_mux = instr_q;
			`RLS_A_PC: rd_mux = {8'h00, pc_q};
			`RLS_A_ENDADDR: rd_mux = {8'h00, end_addr_q};
			`RLS_A_STATUS: rd_mux = {mode_control_reg_one_q, arith_status_reg_q};
			`RLS_A_LATCH: rd_mux = interrupt_latch_reg_q;
			`RLS_A_MASKP: rd_mux = interrupt_mask_pointer_q;
			`RLS_A_COUNT: rd_mux = {16'h0000, current_loop_count_q};
			`RLS_A_PCSTK: rd_mux = {8'h00, pc_top};
			`RLS_A_STSTK: rd_mux = st_top;
			`RLS_A_LSTK: rd_mux = {3'h0, ls_top};
			`RLS_A_CSTK: rd_mux = {16'h0000, cs_top};
			`RLS_A_CMPEN: rd_mux = status_pushed_q;
			default: rd_mux = 32'h00000000;
		endcase
	end
	wire addr_ok = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= `RLS_A_PUSHSEL);
	// One-cycle access phase; unmapped addresses answer with error
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I && !PENABLE_I;
			PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_ok;
			PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rd_mux : 32'h00000000;
		end
	end
	wire unused_ok = apb_rd ^ (|pc_lvl) ^ (|st_lvl) ^ (|ls_lvl) ^ (|cs_lvl);
	chk_return_pops_pc: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ret_take && !ret.delayed_option |=> FETCH_LOAD_O) else $error("return lost");
	chk_fetch_from_top: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ret_take && !ret.delayed_option |=> FETCH_ADDR_O == $past(pc_top))
		else $error("return address wrong");
	chk_delayed_two_slots: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ret_take && ret.delayed_option |=> !FETCH_LOAD_O ##1 !FETCH_LOAD_O ##1 FETCH_LOAD_O)
		else $error("delayed return timing");
	chk_false_keeps_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_ret && !ret_true && !wr_latch |=> $stable(interrupt_latch_reg_q))
		else $error("false return changed latch");
	chk_false_no_redirect: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_ret && !ret_true |=> !FETCH_LOAD_O)
		else $error("false return redirected");
	chk_false_keeps_stacks: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_ret && !ret_true && !wr_push |=> $stable(pc_lvl) && $stable(st_lvl))
		else $error("false return moved a stack");
	chk_status_restored: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		st_pop |=> {mode_control_reg_one_q, arith_status_reg_q} == $past(st_top))
		else $error("status not restored");
	chk_rti_clears_bit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		ret_irq |=> !interrupt_latch_reg_q[$past(ivec)] && !interrupt_mask_pointer_q[$past(ivec)])
		else $error("latch bit not cleared");
	chk_paired_both: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_ret && paired_element_mode_q && !uncond && !COND_SECONDARY_I |-> !ret_take)
		else $error("paired return on one element");
	chk_secondary_gated: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		!paired_element_mode_q |=> !COMPUTE_SECONDARY_O && !SECONDARY_COMPLEMENT_O)
		else $error("secondary ran in single mode");
	chk_loop_loads_count: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_loop |=> current_loop_count_q == $past(instr_q[`RLS_CNT_MSB:`RLS_CNT_LSB]))
		else $error("loop count not loaded");
	chk_count_pushed: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_loop |=> cs_top == $past(instr_q[`RLS_CNT_MSB:`RLS_CNT_LSB]))
		else $error("count stack not pushed");
	chk_loop_start_push: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_loop |=> pc_top == $past(pc_q) + 24'h000001)
		else $error("loop start not pushed");
	chk_loop_end_push: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_loop |=> ls_top == {$past(lp.end_addr), `RLS_LCE_TERM})
		else $error("loop end not pushed");
	chk_else_inverts: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_ret && ret.has_compute && ret.else_form && p_true |=> !COMPUTE_PRIMARY_O)
		else $error("else compute ran on true");
	chk_decr_by_one: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		do_decr && !is_loop |=> current_loop_count_q == $past(current_loop_count_q) - 16'h0001)
		else $error("decrement wrong");
	chk_reentry_no_decr: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		decr_skip_q && at_decr && !is_loop |=> $stable(current_loop_count_q))
		else $error("double decrement");
	chk_stage_select: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		is_loop |=> FETCH_STAGE_LOOP_O == $past(instr_q[`RLS_MODE_BIT]))
		else $error("loop stage wrong");
endmodule : rls_sequencer

// >>> logic/rls_stack.sv
// Small last-in first-out stack with registered top
`timescale 1ns/1ps
module rls_stack #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] top_o,
	output logic [$clog2(DEPTH):0] level_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [$clog2(DEPTH):0] lvl_q;
	wire can_push = push_i && (lvl_q < ($clog2(DEPTH)+1)'(DEPTH));
	wire can_pop = pop_i && (lvl_q != '0);
	wire [$clog2(DEPTH):0] idx_top = lvl_q - 1'b1;
	wire [$clog2(DEPTH):0] idx_below = lvl_q - ($clog2(DEPTH)+1)'(2);
	// Pop wins over push when both arrive; top read after pop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lvl_q <= '0;
		end else if (can_pop) begin
			lvl_q <= lvl_q - 1'b1;
		end else if (can_push) begin
			lvl_q <= lvl_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (can_push && !can_pop) begin
			mem_q[lvl_q[$clog2(DEPTH)-1:0]] <= wdata_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			top_o <= '0;
		end else if (can_pop) begin
			top_o <= (lvl_q > ($clog2(DEPTH)+1)'(1)) ?
				mem_q[idx_below[$clog2(DEPTH)-1:0]] : '0;
		end else if (can_push) begin
			top_o <= wdata_i;
		end else if (lvl_q != '0) begin
			top_o <= mem_q[idx_top[$clog2(DEPTH)-1:0]];
		end
	end
	assign level_o = lvl_q;
endmodule : rls_stack
